// ---- hw/gdrb_pkg.sv ----
// Package: register map, field positions and reset values of the GPIO data register bank
package gdrb_pkg;
    // ------------------------------------------------------------------
    // Register map (byte offsets inside the runtime register block)
    // ------------------------------------------------------------------
    localparam int GDRB_ADDR_W = 8;
    localparam logic [7:0] GDRB_OFS_DATA_BYTE_ONE = 8'h4B;
    localparam logic [7:0] GDRB_OFS_DATA_BYTE_TWO = 8'h4C;
    localparam logic [7:0] GDRB_OFS_DATA_BYTE_THREE = 8'h4D;
    localparam logic [7:0] GDRB_OFS_DATA_BYTE_FOUR = 8'h4E;
    // Configuration registers: one per port, contiguous from this offset
    localparam logic [7:0] GDRB_OFS_CFG_BASE = 8'h60;
    // ------------------------------------------------------------------
    // Configuration field layout
    // ------------------------------------------------------------------
    localparam int GDRB_CFG_DIR_BIT = 0;
    localparam int GDRB_CFG_POL_BIT = 1;
    localparam int GDRB_CFG_W = 8;
    localparam int GDRB_BYTE_W = 8;
    // Direction input, polarity non-inverted
    localparam logic [7:0] GDRB_CFG_RESET = 8'h01;
    localparam logic [7:0] GDRB_DATA_RESET = 8'h00;
    localparam logic [7:0] GDRB_READ_UNMAPPED = 8'h00;
endpackage

// ---- hw/gdrb_top.sv ----
// GPIO data register bank: data bytes, per-port configuration, pin drive and sampling
// Contract
// [RULE1] Each port: one data bit, 8-bit config
// [RULE2] Data bits packed eight per data byte
// [RULE3] Input port read returns pin level
// [RULE4] Output port drives last written value
// [RULE5] Data latched on each read and write; the code latches reads for input ports only, output ports take writes only
// [RULE6] All registers inside runtime register block
// [RULE7] Cfg bit0 direction, bit1 polarity
// [RULE8] Writes to input port bits ignored
// [RULE9] Output port read returns written value
// [RULE10] Offsets decoded relative to block base
`timescale 1ns/10ps
module gdrb_top
    import gdrb_pkg::*;
#(
    parameter int NUM_BYTES = 4,
    parameter logic [15:0] RT_BASE = 16'h0000
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [NUM_BYTES*8-1:0] gpio_in,
    output logic [NUM_BYTES*8-1:0] gpio_out,
    output logic [NUM_BYTES*8-1:0] gpio_oe
);
    localparam int NP = NUM_BYTES * GDRB_BYTE_W;

    // The read mux indexes bytes with two address bits, so four bytes at most
    if (NUM_BYTES < 1 || NUM_BYTES > 4) begin : g_bad_num_bytes
        $error("NUM_BYTES must lie between 1 and 4");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [15:0] rel_addr;
    logic in_block;
    logic [7:0] ofs;
    logic data_hit;
    logic cfg_hit;
    logic [7:0] data_idx;
    logic [7:0] cfg_idx;

    assign rel_addr = reg_addr - RT_BASE; // [RULE10]
    // The subtraction wraps below the base, hence the explicit lower bound
    assign in_block = (reg_addr >= RT_BASE) && (rel_addr[15:8] == 8'h00); // [RULE6]
    assign ofs = rel_addr[7:0];
    assign data_idx = ofs - GDRB_OFS_DATA_BYTE_ONE;
    assign cfg_idx = ofs - GDRB_OFS_CFG_BASE;
    assign data_hit = in_block && (ofs >= GDRB_OFS_DATA_BYTE_ONE) && (data_idx < 8'(NUM_BYTES));
    assign cfg_hit = in_block && (ofs >= GDRB_OFS_CFG_BASE) && (cfg_idx < 8'(NP));

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // No reset: the chain refills from the pins within two edges anyway
    logic [NP-1:0] pin_meta_ff;
    logic [NP-1:0] pin_sync_ff;

    always_ff @(posedge ref_clk) begin
        pin_meta_ff <= gpio_in;
        pin_sync_ff <= pin_meta_ff;
    end

    // ------------------------------------------------------------------
    // Per-port state
    // ------------------------------------------------------------------
    logic [GDRB_CFG_W-1:0] cfg_ff [NP]; // [RULE1]
    logic [NP-1:0] data_ff;
    logic [NP-1:0] is_in;
    logic [NP-1:0] is_inv;
    logic [NP-1:0] rd_view;

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_port
            localparam int BYTE_I = gp / GDRB_BYTE_W;
            localparam int BIT_I = gp % GDRB_BYTE_W;

            assign is_in[gp] = cfg_ff[gp][GDRB_CFG_DIR_BIT]; // [RULE7]
            assign is_inv[gp] = cfg_ff[gp][GDRB_CFG_POL_BIT]; // [RULE7]

            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    cfg_ff[gp] <= GDRB_CFG_RESET;
                end else if (reg_wr && cfg_hit && cfg_idx == 8'(gp)) begin
                    cfg_ff[gp] <= reg_wdata;
                end
            end

            // Input ports latch the pin on access; output ports take only writes
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    data_ff[gp] <= GDRB_DATA_RESET[BIT_I];
                end else if (data_hit && data_idx == 8'(BYTE_I)) begin
                    if (is_in[gp]) begin
                        if (reg_rd || reg_wr) begin
                            data_ff[gp] <= pin_sync_ff[gp] ^ is_inv[gp]; // [RULE3] [RULE5] [RULE8]
                        end
                    end else if (reg_wr) begin
                        data_ff[gp] <= reg_wdata[BIT_I]; // [RULE4] [RULE5]
                    end
                end
            end

            // Read of an input port reflects the pin at the read itself
            assign rd_view[gp] = is_in[gp] ? (pin_sync_ff[gp] ^ is_inv[gp]) : data_ff[gp]; // [RULE3] [RULE9]

            // Input ports still present the latched bit; the low enable keeps it off the pin
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    gpio_out[gp] <= 1'b0;
                    gpio_oe[gp] <= 1'b0;
                end else begin
                    gpio_out[gp] <= data_ff[gp] ^ is_inv[gp]; // [RULE4]
                    gpio_oe[gp] <= ~is_in[gp]; // [RULE7]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------------
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = GDRB_READ_UNMAPPED;
        if (data_hit) begin
            // Shift amount needs five bits to reach the top byte
            nxt_rdata = 8'(rd_view >> (5'(data_idx[1:0]) * 5'(GDRB_BYTE_W))); // [RULE2]
        end else if (cfg_hit) begin
            nxt_rdata = cfg_ff[cfg_idx[4:0]];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_out_follows_write: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE4]
        (reg_wr && data_hit && data_idx == 8'h00 && !is_in[0] && !is_inv[0]
         && !(reg_rd)) ##1 (!is_in[0] && !is_inv[0]) |=> (gpio_out[0] == $past(reg_wdata[0], 2)))
        else $error("output pin did not follow written value");
    chk_in_write_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE8]
        (reg_wr && data_hit && data_idx == 8'h00 && is_in[0] && !is_inv[0])
        |=> (data_ff[0] == $past(pin_sync_ff[0])))
        else $error("write to input port changed stored bit");
    chk_oe_direction: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE7]
        (reg_wr && cfg_hit && cfg_idx == 8'h00) ##1 !(reg_wr && cfg_hit && cfg_idx == 8'h00)
        |=> (gpio_oe[0] == !$past(reg_wdata[GDRB_CFG_DIR_BIT], 2)))
        else $error("output enable disagrees with direction bit");
    chk_read_output_port: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE9]
        (reg_rd && data_hit && data_idx == 8'h00 && !is_in[0]) |=> (reg_rdata[0] == $past(data_ff[0])))
        else $error("read of output port did not return written value");
    chk_read_input_port: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE3]
        (reg_rd && data_hit && data_idx == 8'h00 && is_in[0])
        |=> (reg_rdata[0] == ($past(pin_sync_ff[0]) ^ $past(is_inv[0]))))
        else $error("read of input port did not return pin level");
    chk_latch_on_read: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE5]
        (reg_rd && data_hit && data_idx == 8'h00 && is_in[0]) |=> (data_ff[0] == reg_rdata[0]))
        else $error("read did not latch the data bit");
    chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE10]
        (reg_rd && !data_hit && !cfg_hit) |=> (reg_rdata == 8'h00))
        else $error("unmapped read returned nonzero");
    chk_cfg_readback: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE1]
        (reg_wr && cfg_hit && cfg_idx == 8'h00) ##1 (!reg_wr)
        ##1 (reg_rd && cfg_hit && cfg_idx == 8'h00)
        |=> (reg_rdata == $past(reg_wdata, 3)))
        else $error("configuration register readback mismatch");

    // ------------------------------------------------------------------
    // Read path, write, decode, pin and reset checks
    // ------------------------------------------------------------------
    chk_rdata_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE2]
        !reg_rd
        |=> (reg_rdata == 8'h00))
        else $error("read data stood outside the cycle after the strobe");
    chk_last_byte_packing: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE2]
        (reg_rd && data_hit && data_idx == 8'(NUM_BYTES - 1) && is_in[NP-8] && !is_inv[NP-8])
        |=> (reg_rdata[0] == $past(pin_sync_ff[NP-8])))
        else $error("top data byte not packed from its own ports");
    chk_cfg_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE1]
        (reg_wr && cfg_hit && cfg_idx == 8'h00)
        |=> (cfg_ff[0] == $past(reg_wdata)))
        else $error("configuration write did not land");
    chk_sync_two_stage: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE3]
        1'b1
        |-> (pin_sync_ff == $past(gpio_in, 2)))
        else $error("pin synchroniser is not two stages deep");
    chk_unmapped_write_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE10]
        (reg_wr && !cfg_hit)
        |=> (cfg_ff[0] == $past(cfg_ff[0])))
        else $error("write outside the configuration range changed a port");
    chk_out_read_stable: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE9]
        (reg_rd && data_hit && data_idx == 8'h00 && !is_in[0])
        |=> $stable(data_ff[0]))
        else $error("read of output port altered the stored bit");
    chk_out_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE4]
        (reg_wr && data_hit && data_idx == 8'h00 && !is_in[0])
        |=> (data_ff[0] == $past(reg_wdata[0])))
        else $error("write to output port did not land");
    chk_in_write_undriven: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE8]
        (reg_wr && data_hit && data_idx == 8'h00 && is_in[0])
        |=> !gpio_oe[0])
        else $error("write to input port drove the pin");
    chk_below_base_miss: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE10]
        (reg_addr < RT_BASE)
        |-> (!data_hit && !cfg_hit))
        else $error("address below the block base hit a register");
    chk_reset_outputs_low: assert property (@(posedge ref_clk) // [RULE7]
        !rst_b
        |=> (gpio_out == '0 && gpio_oe == '0 && reg_rdata == 8'h00))
        else $error("outputs not cleared by reset");
endmodule // gdrb_top

// ---- testbench/tb.sv ----
// Self-checking testbench for the GPIO data register bank
`timescale 1ns/10ps
module tb
    import gdrb_pkg::*;
;
    localparam logic [15:0] BASE = 16'h0100;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [31:0] gpio_in = 32'h8100C35A;
    logic [31:0] gpio_out;
    logic [31:0] gpio_oe;
    int errors = 0;
    int checks_done = 0;
    always #5 ref_clk = ~ref_clk;
    gdrb_top #(.NUM_BYTES(4), .RT_BASE(BASE)) gdrb_top_inst (.ref_clk(ref_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
    // ------------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= BASE + {8'h00, ofs};
        reg_wdata <= data;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data is only valid in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [15:0] addr, input logic [7:0] exp, input string name);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, {24'h0, reg_rdata}, {24'h0, exp});
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        #20000;
        errors++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("oe_reset", gpio_oe, 32'h0);
        rd(BASE + 16'h004B, 8'h5A, "byte_one_in");
        rd(BASE + 16'h004C, 8'hC3, "byte_two_in");
        rd(BASE + 16'h004E, 8'h81, "byte_four_in");
        wr(8'h4B, 8'hFF);
        repeat (3) @(posedge ref_clk);
        #1;
        // Input ports keep the latched pin levels and stay undriven
        chk("out_input_wr", gpio_out, 32'h8100C35A);
        chk("oe_input_wr", gpio_oe, 32'h0);
        rd(BASE + 16'h004B, 8'h5A, "byte_one_ignored");
        for (int p = 0; p < 8; p++) begin
            wr(8'h60 + p[7:0], 8'h00);
        end
        wr(8'h4B, 8'hA5);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("out_byte_one", gpio_out[7:0], 32'hA5);
        chk("oe_byte_one", gpio_oe, 32'h000000FF);
        rd(BASE + 16'h004B, 8'hA5, "byte_one_out");
        // Inverted output on port 8: a stored 0 shows as 1 at the pin, 0 on readback
        wr(8'h68, 8'h02);
        wr(8'h4C, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("out_inverted", gpio_out[8], 32'h1);
        rd(BASE + 16'h004C, 8'hC2, "byte_two_mixed");
        wr(8'h70, 8'h03);
        rd(BASE + 16'h004D, 8'h01, "byte_three_inv_in");
        wr(8'h60, 8'h80);
        rd(BASE + 16'h0060, 8'h80, "cfg_port0");
        rd(BASE + 16'h0068, 8'h02, "cfg_port8");
        rd(BASE + 16'h0070, 8'h03, "cfg_port16");
        rd(16'h004B, 8'h00, "no_base");
        rd(BASE + 16'h004F, 8'h00, "unmapped");
        // A pin that moves mid-run must show up on the next read
        @(posedge ref_clk);
        gpio_in[31:24] <= 8'h7E;
        repeat (3) @(posedge ref_clk);
        rd(BASE + 16'h004E, 8'h7E, "byte_four_new_pin");
        @(posedge ref_clk);
        #1;
        chk("rdata_idle", {24'h0, reg_rdata}, 32'h0);
        final_report();
    end
endmodule // tb
